//--- include/rte_pkg.sv
/*
 * Shared constants and carriers of the 8-bit reload timer / event counter:
 * register offsets, field positions, reset values, APB carriers, state.
 * Assumes a 32-bit APB slave with word-aligned registers.
 */
package rte_pkg;

	// ==========================================================
	// Register map
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFS_MODE = 12'h000;
	localparam logic [11:0] OFS_COUNT = 12'h004;
	localparam logic [11:0] OFS_RELOAD = 12'h008;
	localparam logic [11:0] OFS_DUTY = 12'h00C;
	localparam logic [11:0] OFS_IRQ = 12'h010;

	// ==========================================================
	// Field positions
	localparam int MODE_EN_BIT = 7;
	localparam int MODE_RATE_LSB = 4;
	localparam int MODE_EXT_BIT = 3;
	localparam int MODE_FAST_BIT = 2;
	localparam int MODE_PWM_BIT = 0;
	localparam int IRQ_FLAG_BIT = 0;
	localparam int IRQ_IEN_BIT = 1;

	// ==========================================================
	// Values
	localparam logic [7:0] COUNT_RST = 8'h00;
	localparam logic [7:0] RELOAD_RST = 8'h00;
	localparam logic [7:0] DUTY_RST = 8'h00;
	localparam logic [7:0] COUNT_FULL = 8'hFF;
	localparam logic [15:0] OVF_VECTOR = 16'h000C;
	localparam logic [6:0] PRE_RST = 7'h00;
	localparam logic [6:0] PRE_FULL_MASK = 7'h7F;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic enable;
		logic [2:0] rate;
		logic ext_sel;
		logic fast_sel;
		logic pwm_en;
	} rte_mode_t;

	localparam rte_mode_t MODE_RST = '{enable: 1'b0, rate: 3'h0, ext_sel: 1'b0,
		fast_sel: 1'b0, pwm_en: 1'b0};

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} rte_apb_req_t;

	typedef struct packed {
		logic pready;
		logic [31:0] prdata;
		logic pslverr;
	} rte_apb_rsp_t;

	typedef struct packed {
		rte_mode_t mode;
		logic [7:0] count;
		logic [7:0] reload_buf;
		logic [7:0] reload_act;
		logic [7:0] duty;
		logic flag;
		logic ien;
		logic [6:0] pre;
		logic [2:0] ev_sync;
		logic pwm;
		logic pwm_oe_n;
		logic irq;
		logic wake;
		logic [15:0] vector;
		rte_apb_rsp_t rsp;
	} rte_state_t;

endpackage

//--- verilog/rte_timer.sv
/*
 * 8-bit up timer / event counter with double-buffered auto reload,
 * prescaler, overflow flag, interrupt request and PWM output, as an APB slave.
 * Assumes fcpu_tick and fhosc_tick are one-cycle enables synchronous to
 * ref_clk, and that the event pin is asynchronous.
 */
// The implementer's own choices: the register offsets and the APB slave port.
//
// Notes on behaviour
// R01: Count enable bit holds or advances count.
// R02: Eight-bit up counter, one per tick.
// R03: Rollover FF to 00 sets sticky flag.
// R04: Reload writes buffered, copied on overflow.
// R05: Reload always active while enabled.
// R06: Enabled overflow requests interrupt vector 000C.
// R07: Service software clears the flag itself.
// R08: Software configures before setting enable.
// R09: Runs in green mode, never wakes.
// R10: External select picks event pin, else the prescaled clock.
// R11: Instruction clock divided 128 down to 1.
// R12: Oscillator clock divided 128 down to 1.
// R13: Event source ignores the prescale selection.
// R14: Event count advances on falling edges.
// R15: PWM high at period start, low at compare.
// R16: Software loads counter and reload equally first.
// R17: Overflow beats simultaneous software flag clear.
// R18: Event input synchronised before edge detection.
`timescale 1ns/10ps

module rte_timer #(
	parameter int ADDR_W = rte_pkg::ADDR_W
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic pready,
	output logic [31:0] prdata,
	output logic pslverr,
	input wire logic fcpu_tick,
	input wire logic fhosc_tick,
	input wire logic event_input_pin,
	input wire logic green_mode,
	output logic pwm_output_pin,
	output logic pwm_output_oe_n,
	output logic overflow_irq,
	output logic [15:0] irq_vector,
	output logic wake_up
);

	// Decode needs the low five address bits; buses wider than 12 bits are rejected
	if (ADDR_W < 5 || ADDR_W > rte_pkg::ADDR_W) begin : g_addr_w_check
		$error("rte_timer: ADDR_W out of range");
	end

	// ==========================================================
	// Helpers
	function automatic logic [6:0] rate_mask(input logic [2:0] rate);
		rate_mask = rte_pkg::PRE_FULL_MASK >> rate;
	endfunction

	function automatic logic [31:0] byte_word(input logic [7:0] b);
		byte_word = {24'h000000, b};
	endfunction

	rte_pkg::rte_state_t st;
	rte_pkg::rte_state_t next_st;
	rte_pkg::rte_apb_req_t req;
	logic [11:0] addr;
	logic wr;
	logic clr_req;
	logic src_tick;
	logic pre_hit;
	logic ev_fall;
	logic cnt_tick;
	logic ovf;
	logic [7:0] inc;

	assign addr = 12'(paddr);
	assign req = '{psel: psel, penable: penable, pwrite: pwrite, paddr: addr, pwdata: pwdata};
	assign wr = req.psel && req.penable && st.rsp.pready && req.pwrite;
	assign clr_req = wr && req.paddr == rte_pkg::OFS_IRQ && !req.pwdata[rte_pkg::IRQ_FLAG_BIT];
	// Only the second and third sync stages feed the edge detector
	assign ev_fall = st.ev_sync[2] && !st.ev_sync[1]; // R14 R18
	assign src_tick = st.mode.fast_sel ? fhosc_tick : fcpu_tick; // R10
	assign pre_hit = (st.pre & rate_mask(st.mode.rate)) == rate_mask(st.mode.rate); // R11 R12
	assign cnt_tick = st.mode.enable &&
		(st.mode.ext_sel ? ev_fall : (src_tick && pre_hit)); // R01 R10 R13
	assign ovf = cnt_tick && st.count == rte_pkg::COUNT_FULL; // R03
	assign inc = st.count + 8'h01; // R02

	// ==========================================================
	// Next state
	always_comb begin
		next_st = st;
		next_st.ev_sync = {st.ev_sync[1:0], event_input_pin}; // R18

		// Prescaler runs on the chosen source; cleared while stopped for a clean start
		if (!st.mode.enable) begin
			next_st.pre = rte_pkg::PRE_RST;
		end else if (!st.mode.ext_sel && src_tick) begin
			next_st.pre = st.pre + 7'h01;
		end

		if (ovf) begin
			next_st.count = st.reload_buf; // R04 R05
			next_st.reload_act = st.reload_buf; // R04
			next_st.pwm = 1'b1; // R15
		end else if (cnt_tick) begin
			next_st.count = inc; // R01 R02
			if (inc == st.duty) begin
				next_st.pwm = 1'b0; // R15
			end
		end
		if (!st.mode.enable) begin
			next_st.pwm = 1'b1; // R15
		end

		// Register writes; a counter write wins over a tick in the same cycle
		if (wr) begin
			unique case (req.paddr)
				rte_pkg::OFS_MODE: begin
					next_st.mode.enable = req.pwdata[rte_pkg::MODE_EN_BIT];
					next_st.mode.rate = req.pwdata[rte_pkg::MODE_RATE_LSB +: 3];
					next_st.mode.ext_sel = req.pwdata[rte_pkg::MODE_EXT_BIT];
					next_st.mode.fast_sel = req.pwdata[rte_pkg::MODE_FAST_BIT];
					next_st.mode.pwm_en = req.pwdata[rte_pkg::MODE_PWM_BIT];
				end
				rte_pkg::OFS_COUNT: next_st.count = req.pwdata[7:0];
				rte_pkg::OFS_RELOAD: next_st.reload_buf = req.pwdata[7:0]; // R04
				rte_pkg::OFS_DUTY: next_st.duty = req.pwdata[7:0];
				rte_pkg::OFS_IRQ: next_st.ien = req.pwdata[rte_pkg::IRQ_IEN_BIT];
				default: next_st.rsp.pslverr = st.rsp.pslverr;
			endcase
		end

		// Hardware set beats software clear
		if (ovf) begin
			next_st.flag = 1'b1; // R03 R17
		end else if (clr_req) begin
			next_st.flag = 1'b0;
		end

		next_st.irq = st.flag && st.ien; // R06
		next_st.vector = rte_pkg::OVF_VECTOR; // R06
		next_st.wake = 1'b0; // R09
		next_st.pwm_oe_n = !(st.mode.pwm_en && st.mode.enable); // R15
		if (green_mode) begin
			next_st.wake = 1'b0; // R09
		end

		// APB: answer in the first access cycle, no wait states
		next_st.rsp.pready = req.psel && !req.penable;
		next_st.rsp.pslverr = 1'b0;
		next_st.rsp.prdata = 32'h00000000;
		if (req.psel && !req.penable) begin
			unique case (req.paddr)
				rte_pkg::OFS_MODE: next_st.rsp.prdata = byte_word({st.mode.enable,
					st.mode.rate, st.mode.ext_sel, st.mode.fast_sel, 1'b0, st.mode.pwm_en});
				rte_pkg::OFS_COUNT: next_st.rsp.prdata = byte_word(st.count);
				rte_pkg::OFS_RELOAD: next_st.rsp.prdata = 32'h00000000;
				rte_pkg::OFS_DUTY: next_st.rsp.prdata = byte_word(st.duty);
				rte_pkg::OFS_IRQ: next_st.rsp.prdata = byte_word({6'h00, st.ien, st.flag});
				default: next_st.rsp.pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			st <= '{mode: rte_pkg::MODE_RST, count: rte_pkg::COUNT_RST,
				reload_buf: rte_pkg::RELOAD_RST, reload_act: rte_pkg::RELOAD_RST,
				duty: rte_pkg::DUTY_RST, flag: 1'b0, ien: 1'b0, pre: rte_pkg::PRE_RST,
				ev_sync: 3'h7, pwm: 1'b1, pwm_oe_n: 1'b1, irq: 1'b0, wake: 1'b0,
				vector: rte_pkg::OVF_VECTOR,
				rsp: '{pready: 1'b0, prdata: 32'h00000000, pslverr: 1'b0}};
		end else begin
			st <= next_st;
		end
	end

	// ==========================================================
	// Outputs
	assign pready = st.rsp.pready;
	assign prdata = st.rsp.prdata;
	assign pslverr = st.rsp.pslverr;
	assign pwm_output_pin = st.pwm;
	assign pwm_output_oe_n = st.pwm_oe_n;
	assign overflow_irq = st.irq;
	assign irq_vector = st.vector;
	assign wake_up = st.wake;

	// ==========================================================
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence ovf_seq;
		cnt_tick && st.count == 8'hFF;
	endsequence

	sequence ovf_then_flag;
		ovf_seq ##1 st.flag;
	endsequence

	property count_hold;
		!st.mode.enable && !wr |=> $stable(st.count);
	endproperty

	count_hold_a: assert property (count_hold) else $error("count moved while disabled"); // R01

	count_inc_a: assert property (cnt_tick && st.count != 8'hFF && !wr
		|=> st.count == $past(st.count) + 8'h01) else $error("count did not step by one"); // R02

	flag_set_a: assert property (ovf_seq |-> ovf_then_flag) // R03
		else $error("overflow did not set flag");

	set_beats_clear_a: assert property (ovf_seq and clr_req |=> st.flag)
		else $error("clear won over overflow"); // R17

	reload_copy_a: assert property (ovf_seq and !wr |=> st.count == $past(st.reload_buf))
		else $error("reload not copied on overflow"); // R04 R05

	irq_request_a: assert property (ovf_seq and st.ien and !clr_req
		|=> ##1 overflow_irq && irq_vector == 16'h000C) else $error("interrupt not raised"); // R06

	no_wake_a: assert property (green_mode && ovf |=> ##[0:2] !wake_up)
		else $error("wake-up raised"); // R09

	event_count_a: assert property (st.mode.enable && st.mode.ext_sel && ev_fall |-> cnt_tick)
		else $error("event edge not counted"); // R13 R14

	src_select_a: assert property (st.mode.ext_sel && !ev_fall |-> !cnt_tick)
		else $error("internal clock counted in event mode"); // R10

	fast_div1_a: assert property (st.mode.enable && !st.mode.ext_sel && st.mode.rate == 3'h7
		&& (st.mode.fast_sel ? fhosc_tick : fcpu_tick) |-> cnt_tick)
		else $error("divide by one missed a tick"); // R11 R12

	pwm_low_a: assert property (cnt_tick && st.count != 8'hFF && st.count + 8'h01 == st.duty
		&& !wr && st.mode.enable |=> !pwm_output_pin) else $error("pwm not low at compare"); // R15

	pwm_high_a: assert property (ovf_seq |=> pwm_output_pin)
		else $error("pwm not high at period start"); // R15

	// ==========================================================
	// Further checks of register writes, overflow, flag, request, prescaler, event sampling and PWM
	sequence flag_then_irq;
		ovf_seq ##1 st.flag ##1 overflow_irq;
	endsequence

	sequence wr_reload_seq;
		wr && req.paddr == rte_pkg::OFS_RELOAD;
	endsequence

	sequence wr_count_seq;
		wr && req.paddr == rte_pkg::OFS_COUNT;
	endsequence

	irq_chain_a: assert property (ovf_seq and st.ien and !wr |-> flag_then_irq) // R06
		else $error("overflow did not reach the request line");

	disabled_still_a: assert property (!st.mode.enable |-> !cnt_tick) // R01
		else $error("tick while disabled");

	flag_hold_a: assert property (st.flag && !clr_req |=> st.flag) // R03
		else $error("flag dropped without a clear");

	flag_clear_a: assert property (clr_req && !ovf |=> !st.flag) // R03
		else $error("flag clear ignored");

	reload_buffer_a: assert property (wr_reload_seq |=> st.reload_buf == $past(req.pwdata[7:0])) // R04
		else $error("reload write not buffered");

	// A reload write must never disturb the running period
	reload_no_touch_a: assert property (wr_reload_seq and !cnt_tick |=> $stable(st.count)) // R04
		else $error("reload write touched the counter");

	count_write_a: assert property (wr_count_seq |=> st.count == $past(req.pwdata[7:0])) // R02
		else $error("counter write lost");

	irq_follow_a: assert property (1'b1 |=> overflow_irq == $past(st.flag && st.ien)) // R06
		else $error("request line does not follow flag");

	vector_fixed_a: assert property (irq_vector == 16'h000C) // R06
		else $error("vector changed");

	wake_never_a: assert property (!wake_up) // R09
		else $error("wake-up driven");

	green_count_a: assert property (green_mode && cnt_tick && st.count != 8'hFF && !wr // R09
		|=> st.count != $past(st.count)) else $error("counting stopped in green mode");

	pre_clear_a: assert property (!st.mode.enable |=> st.pre == 7'h00) // R11
		else $error("prescaler not cleared while stopped");

	pre_step_a: assert property (st.mode.enable && !st.mode.ext_sel && src_tick // R11 R12
		|=> st.pre == $past(st.pre) + 7'h01) else $error("prescaler missed a source tick");

	pre_hold_a: assert property (st.mode.enable && (st.mode.ext_sel || !src_tick) // R13
		|=> $stable(st.pre)) else $error("prescaler moved without a source tick");

	fast_pick_a: assert property (st.mode.enable && !st.mode.ext_sel // R12
		&& !(st.mode.fast_sel ? fhosc_tick : fcpu_tick) |-> !cnt_tick)
		else $error("tick without the selected source");

	sync_first_a: assert property (1'b1 |=> st.ev_sync[0] == $past(event_input_pin)) // R18
		else $error("event pin not sampled");

	// A high or rising event level must never count
	no_rise_count_a: assert property (st.mode.ext_sel && st.ev_sync[1] |-> !cnt_tick) // R14
		else $error("count on a non-falling event level");

	pwm_idle_a: assert property (!st.mode.enable |=> pwm_output_pin) // R15
		else $error("pwm not idle high while stopped");

	pwm_enable_a: assert property (1'b1 // R15
		|=> pwm_output_oe_n == !$past(st.mode.pwm_en && st.mode.enable))
		else $error("pwm drive enable wrong");

endmodule

//--- verification/rte_timer_tb.sv
/*
 * Self-checking bench of the reload timer / event counter: APB register
 * access, prescaled periods seen on the PWM pin, event counting, flag.
 * Assumes the APB slave answers in the first access cycle.
 */
`timescale 1ns/10ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
	$display("unexpected at %0t got %h exp %h", $time, g, e); end end

module rte_timer_tb;
	logic ref_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'hD22F, v;
	logic fcpu_tick = 0, fhosc_tick = 0, event_input_pin = 1, green_mode = 0;
	logic pready, pslverr, pwm_output_pin, pwm_output_oe_n, overflow_irq, wake_up;
	logic [15:0] irq_vector;
	logic [33:0] exp_q[$];
	logic [33:0] cur;
	int fails = 0, checks_done = 0, c;

	rte_timer uut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .fcpu_tick(fcpu_tick),
		.fhosc_tick(fhosc_tick), .event_input_pin(event_input_pin),
		.green_mode(green_mode), .pwm_output_pin(pwm_output_pin),
		.pwm_output_oe_n(pwm_output_oe_n), .overflow_irq(overflow_irq),
		.irq_vector(irq_vector), .wake_up(wake_up));

	// ==========================================================
	// Clock, ticks and helpers
	initial begin
		forever #20 ref_clk = ~ref_clk;
	end

	// Fixed tick rates keep the expected periods exact
	always @(posedge ref_clk) begin
		fcpu_tick <= 1'b1;
		fhosc_tick <= ~fhosc_tick;
	end

	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction

	task tally_and_finish();
		$display("fails=%0d checks_done=%0d", fails, checks_done);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Entry: {compare data, expected pslverr, expected data}
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [33:0] e);
		int i;
		exp_q.push_back(e);
		@(posedge ref_clk);
		psel <= 1;
		penable <= 0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1;
		i = 0;
		do begin
			@(posedge ref_clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			fails++;
			tally_and_finish();
		end
		psel <= 0;
		penable <= 0;
	endtask

	task wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 34'h0);
	endtask

	task rd(input logic [11:0] a, input logic [31:0] d);
		apb(1'b0, a, 32'h0, {2'b10, d});
	endtask

	// Cycles from one rising PWM edge to the next
	task rise(output int n);
		n = 0;
		while (pwm_output_pin === 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		while (pwm_output_pin !== 1'b1 && n < 3000) begin
			@(negedge ref_clk);
			n++;
		end
		if (n >= 3000) begin
			fails++;
			tally_and_finish();
		end
	endtask

	task period(input logic fast, input logic [2:0] r);
		wr(rte_pkg::OFS_MODE, 32'h0);
		wr(rte_pkg::OFS_COUNT, 32'hFC);
		wr(rte_pkg::OFS_RELOAD, 32'hFC);
		wr(rte_pkg::OFS_DUTY, 32'hFE);
		wr(rte_pkg::OFS_MODE, {24'h0, 1'b1, r, 1'b0, fast, 2'b01});
		rise(c);
		rise(c);
		`CHK(c, 4 * (128 >> r) * (fast ? 2 : 1))
		`CHK(pwm_output_oe_n, 1'b0)
	endtask

	// ==========================================================
	// Response watcher
	always @(posedge ref_clk) begin
		if (psel && penable && pready === 1'b1) begin
			if (exp_q.size() == 0) begin
				fails++;
				$display("unexpected at %0t got %h exp %h", $time, prdata, 32'h0);
			end else begin
				cur = exp_q.pop_front();
				`CHK(pslverr, cur[32])
				if (cur[33])
					`CHK(prdata, cur[31:0])
			end
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 0;
		@(negedge ref_clk);
		`CHK(pwm_output_pin, 1'b1)
		`CHK(overflow_irq, 1'b0)
		rd(rte_pkg::OFS_COUNT, 32'h0);
		rd(rte_pkg::OFS_MODE, 32'h0);
		rd(rte_pkg::OFS_RELOAD, 32'h0);
		apb(1'b0, 12'h014, 32'h0, {2'b01, 32'h0});
		repeat (3) begin
			v = rnd() & 32'hFF;
			wr(rte_pkg::OFS_COUNT, v);
			repeat (8) @(posedge ref_clk);
			rd(rte_pkg::OFS_COUNT, v);
		end
		green_mode <= 1;
		for (int f = 0; f < 2; f++)
			for (int r = 0; r < 8; r++)
				period(f[0], r[2:0]);
		// New reload only takes hold from the next period
		wr(rte_pkg::OFS_RELOAD, 32'hFA);
		rise(c);
		rise(c);
		`CHK(c, 12)
		wr(rte_pkg::OFS_MODE, 32'h0);
		wr(rte_pkg::OFS_COUNT, 32'hFD);
		wr(rte_pkg::OFS_RELOAD, 32'h10);
		wr(rte_pkg::OFS_IRQ, 32'h2);
		wr(rte_pkg::OFS_MODE, 32'h89);
		repeat (3) begin
			repeat (4) @(posedge ref_clk);
			event_input_pin <= 0;
			repeat (4) @(posedge ref_clk);
			event_input_pin <= 1;
		end
		repeat (6) @(posedge ref_clk);
		rd(rte_pkg::OFS_COUNT, 32'h10);
		rd(rte_pkg::OFS_IRQ, 32'h3);
		@(negedge ref_clk);
		`CHK(overflow_irq, 1'b1)
		`CHK(irq_vector, 16'h000C)
		`CHK(wake_up, 1'b0)
		wr(rte_pkg::OFS_IRQ, 32'h2);
		rd(rte_pkg::OFS_IRQ, 32'h2);
		@(negedge ref_clk);
		@(negedge ref_clk);
		`CHK(overflow_irq, 1'b0)
		tally_and_finish();
	end

	initial begin
		#2000000;
		fails++;
		tally_and_finish();
	end
endmodule
